// ---- verilog/gio_pkg.sv ----
package gio_pkg;
   localparam int unsigned LINES    = 20;
   localparam int unsigned AUX      = 2;
   localparam int unsigned DW       = 32;
   localparam int unsigned AW       = 4;
   localparam int unsigned BYTE_W   = 8;
   localparam int unsigned BYTE_HI  = 8;

   // register word indices on the bus
   localparam logic [AW-1:0] REG_DIR     = 4'h0;
   localparam logic [AW-1:0] REG_OUT     = 4'h1;
   localparam logic [AW-1:0] REG_IN      = 4'h2;
   localparam logic [AW-1:0] REG_PULLUP  = 4'h3;
   localparam logic [AW-1:0] REG_EDGE    = 4'h4;
   localparam logic [AW-1:0] REG_ENABLE  = 4'h5;
   localparam logic [AW-1:0] REG_STATUS  = 4'h6;
   localparam logic [AW-1:0] REG_BYTE_LO = 4'h7;
   localparam logic [AW-1:0] REG_BYTE_HI = 4'h8;
   localparam logic [AW-1:0] REG_AUX     = 4'h9;

   localparam logic [1:0] RESP_OK     = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef logic [LINES-1:0] gio_line_t;

   localparam gio_line_t DIR_RST  = 20'h00000;
   localparam gio_line_t OUT_RST  = 20'h00000;
   localparam gio_line_t PU_RST   = 20'hFFFFF;
   localparam gio_line_t EDGE_RST = 20'h00000;
   localparam gio_line_t EN_RST   = 20'h00000;

   typedef struct packed {
      gio_line_t o;
      gio_line_t oe;
      gio_line_t pu;
   } gio_pad_t;

   typedef struct packed {
      logic [AUX-1:0] pu;
      logic [AUX-1:0] dat;
      logic [AUX-1:0] en;
   } gio_aux_cfg_t;

   localparam gio_aux_cfg_t AUX_CFG_RST = 6'h3C;

   typedef struct packed {
      logic [AUX-1:0] o;
      logic [AUX-1:0] oe;
      logic [AUX-1:0] pu;
   } gio_aux_pad_t;
endpackage

// ---- verilog/gio_edge_detect.sv ----
`timescale 1ns/100ps
module gio_edge_detect (
   input  wire logic          clock_in,
   input  wire logic          rst_n_in,
   input  gio_pkg::gio_line_t pin_in,
   input  gio_pkg::gio_line_t fall_sel_in,
   input  gio_pkg::gio_line_t watch_in,
   input  gio_pkg::gio_line_t clear_in,
   output gio_pkg::gio_line_t status_out
);
   typedef struct packed {
      logic               armed;
      gio_pkg::gio_line_t prev;
      gio_pkg::gio_line_t status;
   } gio_edge_state_t;

   gio_edge_state_t    st_q;
   gio_edge_state_t    st_d;
   gio_pkg::gio_line_t hit;

   genvar i;
   generate
      for (i = 0; i < gio_pkg::LINES; i++) begin : g_line
         // armed keeps the first sample after reset from faking an edge
         assign hit[i] = st_q.armed & watch_in[i] &
                         (fall_sel_in[i] ? (st_q.prev[i] & ~pin_in[i])
                                         : (~st_q.prev[i] & pin_in[i]));
      end
   endgenerate

   always_comb begin
      st_d        = st_q;
      st_d.armed  = 1'b1;
      st_d.prev   = pin_in;
      // new event wins over a clear in the same cycle
      st_d.status = (st_q.status & ~clear_in) | hit;
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign status_out = st_q.status;
endmodule

// ---- verilog/gio_aux_out.sv ----
`timescale 1ns/100ps
module gio_aux_out (
   input  wire logic                   clock_in,
   input  wire logic                   rst_n_in,
   input  wire logic                   wr_in,
   input  gio_pkg::gio_aux_cfg_t       wdata_in,
   input  gio_pkg::gio_aux_cfg_t       wmask_in,
   input  wire logic                   sleep_in,
   input  wire logic [gio_pkg::AUX-1:0] periph_o_in,
   input  wire logic [gio_pkg::AUX-1:0] periph_oe_in,
   output gio_pkg::gio_aux_cfg_t       cfg_out,
   output gio_pkg::gio_aux_pad_t       pad_out
);
   typedef struct packed {
      gio_pkg::gio_aux_cfg_t cfg;
      gio_pkg::gio_aux_pad_t pad;
   } gio_aux_state_t;

   gio_aux_state_t st_q;
   gio_aux_state_t st_d;

   always_comb begin
      st_d = st_q;
      if (wr_in) begin
         st_d.cfg = (st_q.cfg & ~wmask_in) | (wdata_in & wmask_in);
      end
      if (sleep_in) begin
         st_d.cfg = gio_pkg::AUX_CFG_RST;
      end
      // when not enabled for general output the peripherals own the pins
      st_d.pad.o  = (st_q.cfg.en & st_q.cfg.dat) |
                    (~st_q.cfg.en & periph_o_in);
      st_d.pad.oe = st_q.cfg.en | periph_oe_in;
      st_d.pad.pu = st_q.cfg.pu;
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q.cfg <= gio_pkg::AUX_CFG_RST;
         st_q.pad <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign cfg_out = st_q.cfg;
   assign pad_out = st_q.pad;
endmodule

// ---- verilog/gio_port.sv ----
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
module gio_port (
   input  wire logic                    clock_in,
   input  wire logic                    rst_n_in,
   // Avalon-MM slave, word addressed
   input  wire logic [gio_pkg::AW-1:0]  avs_address_in,
   input  wire logic                    avs_read_in,
   input  wire logic                    avs_write_in,
   input  wire logic [gio_pkg::DW-1:0]  avs_writedata_in,
   input  wire logic [3:0]              avs_byteenable_in,
   output logic [gio_pkg::DW-1:0]       avs_readdata_out,
   output logic [1:0]                   avs_response_out,
   output logic                         avs_waitrequest_out,
   // general io lines
   input  gio_pkg::gio_line_t           general_io_line_in,
   output gio_pkg::gio_line_t           general_io_line_out,
   output gio_pkg::gio_line_t           general_io_line_oe_out,
   output gio_pkg::gio_line_t           general_io_line_pu_out,
   // shared peripheral overrides
   input  gio_pkg::gio_line_t           periph_own_in,
   input  gio_pkg::gio_line_t           periph_o_in,
   input  gio_pkg::gio_line_t           periph_oe_in,
   input  gio_pkg::gio_line_t           xtal_attach_in,
   // auxiliary outputs, bit 0 aux_output_zero, bit 1 aux_output_one
   input  wire logic [gio_pkg::AUX-1:0] aux_periph_o_in,
   input  wire logic [gio_pkg::AUX-1:0] aux_periph_oe_in,
   output logic [gio_pkg::AUX-1:0]      aux_output_out,
   output logic [gio_pkg::AUX-1:0]      aux_output_oe_out,
   output logic [gio_pkg::AUX-1:0]      aux_output_pu_out,
   // system controller
   input  wire logic                    sleep_in,
   output logic                         syscon_irq_out,
   output logic                         wake_out
);
   typedef struct packed {
      gio_pkg::gio_line_t  dir;
      gio_pkg::gio_line_t  lvl;
      gio_pkg::gio_line_t  pu;
      gio_pkg::gio_line_t  fall;
      gio_pkg::gio_line_t  en;
      logic                ack;
      logic [gio_pkg::DW-1:0] rdata;
      logic [1:0]          resp;
      gio_pkg::gio_pad_t   pad;
      logic                irq;
      logic                wake;
   } gio_port_state_t;

   gio_port_state_t        st_q;
   gio_port_state_t        st_d;

   logic                   req;
   logic                   commit_wr;
   logic [gio_pkg::DW-1:0] wmask;
   gio_pkg::gio_line_t     wd_line;
   gio_pkg::gio_line_t     wm_line;
   gio_pkg::gio_line_t     eff_oe;
   gio_pkg::gio_line_t     status;
   gio_pkg::gio_line_t     status_clr;
   gio_pkg::gio_aux_cfg_t  aux_cfg;
   gio_pkg::gio_aux_pad_t  aux_pad;
   logic                   aux_wr;
   logic [gio_pkg::DW-1:0] rd_word;
   logic                   rd_hit;

   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_be
         assign wmask[8*b +: 8] = {8{avs_byteenable_in[b]}};
      end
   endgenerate

   // one wait cycle per access: request seen, then answered
   assign req       = avs_read_in | avs_write_in;
   assign commit_wr = avs_write_in & st_q.ack;
   assign wd_line   = avs_writedata_in[gio_pkg::LINES-1:0];
   assign wm_line   = wmask[gio_pkg::LINES-1:0];

   // a peripheral owning a line takes over its driver
   assign eff_oe = (periph_own_in & periph_oe_in) |
                   (~periph_own_in & st_q.dir);

   assign status_clr = (commit_wr &&
                        avs_address_in == gio_pkg::REG_STATUS)
                       ? (wd_line & wm_line) : '0;

   assign aux_wr = commit_wr && avs_address_in == gio_pkg::REG_AUX;

   gio_edge_detect u_edge (
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .pin_in      (general_io_line_in),
      .fall_sel_in (st_q.fall),
      .watch_in    (~eff_oe),
      .clear_in    (status_clr),
      .status_out  (status)
   );

   gio_aux_out u_aux (
      .clock_in     (clock_in),
      .rst_n_in     (rst_n_in),
      .wr_in        (aux_wr),
      .wdata_in     (avs_writedata_in[5:0]),
      .wmask_in     (wmask[5:0]),
      .sleep_in     (sleep_in),
      .periph_o_in  (aux_periph_o_in),
      .periph_oe_in (aux_periph_oe_in),
      .cfg_out      (aux_cfg),
      .pad_out      (aux_pad)
   );

   // read decode
   always_comb begin
      rd_word = '0;
      rd_hit  = 1'b1;
      case (avs_address_in)
         gio_pkg::REG_DIR: begin
            rd_word = 32'(st_q.dir);
         end
         gio_pkg::REG_OUT: begin
            rd_word = 32'(st_q.lvl);
         end
         gio_pkg::REG_IN: begin
            rd_word = 32'(general_io_line_in);
         end
         gio_pkg::REG_PULLUP: begin
            rd_word = 32'(st_q.pu);
         end
         gio_pkg::REG_EDGE: begin
            rd_word = 32'(st_q.fall);
         end
         gio_pkg::REG_ENABLE: begin
            rd_word = 32'(st_q.en);
         end
         gio_pkg::REG_STATUS: begin
            rd_word = 32'(status);
         end
         gio_pkg::REG_BYTE_LO: begin
            rd_word = 32'(general_io_line_in[gio_pkg::BYTE_W-1:0]);
         end
         gio_pkg::REG_BYTE_HI: begin
            rd_word = 32'(general_io_line_in[gio_pkg::BYTE_HI +:
                                             gio_pkg::BYTE_W]);
         end
         gio_pkg::REG_AUX: begin
            rd_word = 32'(aux_cfg);
         end
         default: begin
            rd_word = '0;
            rd_hit  = 1'b0;
         end
      endcase
   end

   always_comb begin
      st_d     = st_q;
      st_d.ack = req & ~st_q.ack;

      // answer is latched while the request waits
      if (req && !st_q.ack) begin
         st_d.resp = rd_hit ? gio_pkg::RESP_OK : gio_pkg::RESP_DECERR;
         if (avs_read_in) begin
            st_d.rdata = rd_word;
         end
      end

      if (commit_wr) begin
         case (avs_address_in)
            gio_pkg::REG_DIR: begin
               st_d.dir = (st_q.dir & ~wm_line) |
                          (wd_line & wm_line);
            end
            gio_pkg::REG_OUT: begin
               st_d.lvl = (st_q.lvl & ~wm_line) |
                          (wd_line & wm_line);
            end
            gio_pkg::REG_PULLUP: begin
               st_d.pu = (st_q.pu & ~wm_line) |
                         (wd_line & wm_line);
            end
            gio_pkg::REG_EDGE: begin
               st_d.fall = (st_q.fall & ~wm_line) |
                           (wd_line & wm_line);
            end
            gio_pkg::REG_ENABLE: begin
               st_d.en = (st_q.en & ~wm_line) |
                         (wd_line & wm_line);
            end
            gio_pkg::REG_BYTE_LO: begin
               if (avs_byteenable_in[0]) begin
                  st_d.lvl[gio_pkg::BYTE_W-1:0] =
                     avs_writedata_in[gio_pkg::BYTE_W-1:0];
               end
            end
            gio_pkg::REG_BYTE_HI: begin
               if (avs_byteenable_in[0]) begin
                  st_d.lvl[gio_pkg::BYTE_HI +: gio_pkg::BYTE_W] =
                     avs_writedata_in[gio_pkg::BYTE_W-1:0];
               end
            end
            default: begin
               st_d.dir = st_q.dir;
            end
         endcase
      end

      // stored level drives only while the line is an output
      st_d.pad.o  = (periph_own_in & periph_o_in) |
                    (~periph_own_in & st_q.lvl);
      st_d.pad.oe = eff_oe;
      st_d.pad.pu = st_q.pu & ~(periph_own_in & xtal_attach_in);

      // edge detect keeps running in sleep on the always-on clock
      st_d.irq  = |(status & st_q.en);
      st_d.wake = sleep_in & |(status & st_q.en);
   end

   // sleep never resets this state, so pull-ups are held through it
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q.dir    <= gio_pkg::DIR_RST;
         st_q.lvl    <= gio_pkg::OUT_RST;
         st_q.pu     <= gio_pkg::PU_RST;
         st_q.fall   <= gio_pkg::EDGE_RST;
         st_q.en     <= gio_pkg::EN_RST;
         st_q.ack    <= 1'b0;
         st_q.rdata  <= '0;
         st_q.resp   <= gio_pkg::RESP_OK;
         st_q.pad.o  <= '0;
         st_q.pad.oe <= '0;
         st_q.pad.pu <= gio_pkg::PU_RST;
         st_q.irq    <= 1'b0;
         st_q.wake   <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign avs_waitrequest_out    = req & ~st_q.ack;
   assign avs_readdata_out       = st_q.rdata;
   assign avs_response_out       = st_q.resp;
   assign general_io_line_out    = st_q.pad.o;
   assign general_io_line_oe_out = st_q.pad.oe;
   assign general_io_line_pu_out = st_q.pad.pu;
   assign aux_output_out         = aux_pad.o;
   assign aux_output_oe_out      = aux_pad.oe;
   assign aux_output_pu_out      = aux_pad.pu;
   assign syscon_irq_out         = st_q.irq;
   assign wake_out               = st_q.wake;
endmodule

// ---- dv/gio_port_sva.sv ----
`timescale 1ns/100ps
module gio_port_sva (
   input wire logic                    clock_in,
   input wire logic                    rst_n_in,
   input wire logic [gio_pkg::AW-1:0]  avs_address_in,
   input wire logic                    avs_read_in,
   input wire logic                    avs_write_in,
   input wire logic [gio_pkg::DW-1:0]  avs_readdata_out,
   input wire logic [1:0]              avs_response_out,
   input wire logic                    avs_waitrequest_out,
   input gio_pkg::gio_line_t           general_io_line_out,
   input gio_pkg::gio_line_t           general_io_line_oe_out,
   input gio_pkg::gio_line_t           general_io_line_pu_out,
   input gio_pkg::gio_line_t           periph_own_in,
   input gio_pkg::gio_line_t           periph_o_in,
   input gio_pkg::gio_line_t           periph_oe_in,
   input gio_pkg::gio_line_t           xtal_attach_in,
   input wire logic [gio_pkg::AUX-1:0] aux_periph_oe_in,
   input wire logic [gio_pkg::AUX-1:0] aux_output_oe_out,
   input wire logic [gio_pkg::AUX-1:0] aux_output_pu_out,
   input wire logic                    sleep_in,
   input wire logic                    syscon_irq_out,
   input wire logic                    wake_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   chk_wait_one: assert property ((avs_read_in | avs_write_in)
      && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("waitrequest held past one cycle");
   chk_resp_map: assert property ((avs_read_in | avs_write_in)
      && !avs_waitrequest_out |-> avs_response_out ==
      ((avs_address_in > gio_pkg::REG_AUX) ? gio_pkg::RESP_DECERR
                                           : gio_pkg::RESP_OK))
      else $error("response does not match address");
   chk_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out
      && avs_address_in > gio_pkg::REG_AUX |-> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   chk_upper_zero: assert property (
      avs_read_in && !avs_waitrequest_out
      |-> avs_readdata_out[31:20] == 12'h0)
      else $error("unused upper read bits set");
   chk_own_dir: assert property (
      ((general_io_line_oe_out ^ $past(periph_oe_in))
      & $past(periph_own_in)) == 20'h0)
      else $error("owned line enable not from peripheral");
   chk_own_level: assert property (
      ((general_io_line_out ^ $past(periph_o_in))
      & $past(periph_own_in)) == 20'h0)
      else $error("owned line level not from peripheral");
   chk_xtal_pu: assert property (
      (general_io_line_pu_out & $past(periph_own_in & xtal_attach_in))
      == 20'h0)
      else $error("pull-up on crystal line");
   chk_wake_gate: assert property (
      wake_out |-> $past(sleep_in) && syscon_irq_out)
      else $error("wake without sleep or request");
   chk_aux_sleep: assert property (
      sleep_in |-> ##2 (aux_output_pu_out == 2'h3
      && aux_output_oe_out == $past(aux_periph_oe_in)))
      else $error("aux pins not reverted in sleep");
endmodule

bind gio_port gio_port_sva u_chk (.*);

// ---- dv/gio_pins_model.sv ----
`timescale 1ns/100ps
module gio_pins_model (
   input  wire logic         clock_in,
   input  gio_pkg::gio_line_t o_in,
   input  gio_pkg::gio_line_t oe_in,
   input  gio_pkg::gio_line_t pu_in,
   input  gio_pkg::gio_line_t ext_en_in,
   input  gio_pkg::gio_line_t ext_val_in,
   output gio_pkg::gio_line_t pin_out
);
   gio_pkg::gio_line_t flip_q = 20'h55555;
   // undriven lines without pull-up wander every cycle
   always_ff @(posedge clock_in) begin
      flip_q <= ~flip_q;
   end
   assign pin_out = (oe_in & o_in) | (~oe_in & ext_en_in & ext_val_in)
                  | (~oe_in & ~ext_en_in & (pu_in | flip_q));
endmodule

// ---- dv/test_gio_port.sv ----
`timescale 1ns/100ps
module test_gio_port;
   logic clock_in = 0, rst_n_in = 0, rd = 0, wr = 0, sleep_in = 0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic [1:0]  resp, r, aux_o = 2'h0, aux_oe = 2'h0, ao, aoe, apu;
   logic        wreq, irq, wake;
   gio_pkg::gio_line_t pin, lo, loe, lpu, own = 0, po = 0, poe = 0, xt = 0;
   gio_pkg::gio_line_t ext_en = 0, ext_val = 0;
   int n_mismatch = 0, comparisons = 0;
   gio_port u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdata), .avs_response_out(resp),
      .avs_waitrequest_out(wreq), .general_io_line_in(pin),
      .general_io_line_out(lo), .general_io_line_oe_out(loe),
      .general_io_line_pu_out(lpu), .periph_own_in(own), .periph_o_in(po),
      .periph_oe_in(poe), .xtal_attach_in(xt), .aux_periph_o_in(aux_o),
      .aux_periph_oe_in(aux_oe), .aux_output_out(ao),
      .aux_output_oe_out(aoe), .aux_output_pu_out(apu),
      .sleep_in(sleep_in), .syscon_irq_out(irq), .wake_out(wake));
   gio_pins_model u_pins (.clock_in(clock_in), .o_in(lo), .oe_in(loe),
      .pu_in(lpu), .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_out(pin));
   initial begin
      forever #5 clock_in = ~clock_in;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input string name, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", name, e, g);
         n_mismatch++;
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clock_in);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      for (n = 0; n < 20; n++) begin
         @(posedge clock_in);
         if (wreq === 1'b0) break;
      end
      if (n == 20) begin
         n_mismatch++;
         print_verdict();
      end
      q = rdata;
      r = resp;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdc(input string nm, input logic [3:0] a,
                      input logic [31:0] e);
      bus(0, a, 32'h0);
      cmp(nm, e, q);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   logic [3:0]  ra [7] = '{gio_pkg::REG_DIR, gio_pkg::REG_OUT,
      gio_pkg::REG_PULLUP, gio_pkg::REG_EDGE, gio_pkg::REG_ENABLE,
      gio_pkg::REG_STATUS, gio_pkg::REG_AUX};
   logic [31:0] rv [7] = '{{12'h0, gio_pkg::DIR_RST},
      {12'h0, gio_pkg::OUT_RST},
      {12'h0, gio_pkg::PU_RST}, {12'h0, gio_pkg::EDGE_RST},
      {12'h0, gio_pkg::EN_RST}, 32'h0, {26'h0, gio_pkg::AUX_CFG_RST}};
   initial begin
      repeat (10) @(posedge clock_in);
      rst_n_in <= 1'b1;
      settle(2);
      cmp("oe", 32'h0, loe);
      cmp("pu", 32'hFFFFF, lpu);
      cmp("aux pu", 32'h3, apu);
      cmp("aux oe", 32'h0, aoe);
      for (int i = 0; i < 7; i++) rdc("reset value", ra[i], rv[i]);
      $display("test reset done");
      bus(1, gio_pkg::REG_OUT, 32'hA5A5A);
      settle(2);
      cmp("oe input", 32'h0, loe);
      rdc("in pulled", gio_pkg::REG_IN, 32'hFFFFF);
      bus(1, gio_pkg::REG_DIR, 32'hFFFFF);
      settle(2);
      cmp("out", 32'hA5A5A, lo);
      rdc("in driven", gio_pkg::REG_IN, 32'hA5A5A);
      bus(1, gio_pkg::REG_BYTE_HI, 32'h3C);
      bus(1, gio_pkg::REG_BYTE_LO, 32'h81);
      rdc("out word", gio_pkg::REG_OUT, 32'hA3C81);
      settle(3);
      rdc("byte lo", gio_pkg::REG_BYTE_LO, 32'h81);
      rdc("byte hi", gio_pkg::REG_BYTE_HI, 32'h3C);
      $display("test output done");
      own <= 20'h000F0;
      xt <= 20'h00010;
      po <= 20'h000A0;
      poe <= 20'h00030;
      bus(1, gio_pkg::REG_DIR, 32'h000FF);
      bus(1, gio_pkg::REG_OUT, 32'h000FF);
      settle(2);
      cmp("owned oe", 32'h0003F, loe);
      cmp("owned out", 32'h000AF, lo);
      cmp("xtal pu", 32'hFFFEF, lpu);
      own <= 20'h0;
      settle(3);
      cmp("released oe", 32'h000FF, loe);
      cmp("released out", 32'h000FF, lo);
      $display("test ownership done");
      bus(1, gio_pkg::REG_DIR, 32'h0);
      bus(1, gio_pkg::REG_PULLUP, 32'h0F0F0);
      bus(1, gio_pkg::REG_EDGE, 32'h2);
      ext_en <= 20'hFFFFF;
      ext_val <= 20'h00002;
      settle(4);
      bus(1, gio_pkg::REG_STATUS, 32'hFFFFF);
      ext_val <= 20'h00001;
      settle(4);
      rdc("status polled", gio_pkg::REG_STATUS, 32'h3);
      cmp("irq off", 32'h0, irq);
      bus(1, gio_pkg::REG_ENABLE, 32'h1);
      settle(2);
      cmp("irq on", 32'h1, irq);
      ext_val <= 20'h00005;
      settle(4);
      rdc("status sticky", gio_pkg::REG_STATUS, 32'h7);
      bus(1, gio_pkg::REG_STATUS, 32'h1);
      rdc("status cleared", gio_pkg::REG_STATUS, 32'h6);
      settle(2);
      cmp("irq cleared", 32'h0, irq);
      bus(1, gio_pkg::REG_AUX, 32'h07);
      settle(3);
      cmp("aux out", 32'h1, ao);
      cmp("aux oe on", 32'h3, aoe);
      cmp("aux pu off", 32'h0, apu);
      $display("test edges done");
      sleep_in <= 1'b1;
      bus(1, gio_pkg::REG_ENABLE, 32'h4);
      settle(3);
      cmp("wake", 32'h1, wake);
      cmp("pu in sleep", 32'h0F0F0, lpu);
      cmp("aux pu sleep", 32'h3, apu);
      rdc("aux cfg sleep", gio_pkg::REG_AUX, 32'h3C);
      sleep_in <= 1'b0;
      settle(2);
      rst_n_in <= 1'b0;
      settle(2);
      rst_n_in <= 1'b1;
      settle(2);
      rdc("status after reset", gio_pkg::REG_STATUS, 32'h0);
      rdc("unmapped", 4'hF, 32'h0);
      cmp("unmapped resp", {30'h0, gio_pkg::RESP_DECERR}, r);
      bus(1, gio_pkg::REG_IN, 32'h0);
      cmp("in write resp", {30'h0, gio_pkg::RESP_OK}, r);
      $display("test sleep and reset done");
      print_verdict();
   end
   initial begin
      #400000;
      n_mismatch++;
      print_verdict();
   end
endmodule
